// >>> tb/test_tsc_serial_regs.sv
`timescale 1ns/10ps
module test_tsc_serial_regs
  import tsc_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         power_down_control_n_i = 1'b1;
  logic         idle_n_i = 1'b1;
  logic [2:0]   src = 3'h0;
  logic         link_clk_i, select_n_i, serial_data_in_i, lock_indicator_o;
  logic [15:0]  main_divider_ratio_o;
  logic [8:0]   reference_divide_value_o;
  logic [2:0]   pump_test_select_o;
  tsc_ctrl_type ctrl_o, got;
  int           failures = 0;
  int           checks = 0;
  logic [15:0]  cw [5] = '{16'hfffe, 16'h7fff, 16'hffff, 16'h0004, 16'h9efd};
  logic [1:0]   pv [3] = '{2'b10, 2'b01, 2'b11};
  always #5 clk_i = ~clk_i;
  tsc_host_model host_u (.link_clk_o(link_clk_i), .select_n_o(select_n_i),
    .data_o(serial_data_in_i));
  tsc_serial_regs dut_u (.clk_i, .rst_i, .link_clk_i, .select_n_i, .serial_data_in_i,
    .power_down_control_n_i, .idle_n_i, .pll_lock_detect_i(src[0]), .main_div_out_i(src[1]),
    .ref_div_out_i(src[2]), .main_divider_ratio_o, .reference_divide_value_o,
    .pump_test_select_o, .ctrl_o, .lock_indicator_o);
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] d, input logic [3:0] a, input logic s = 1'b1);
    host_u.send(d, a, s);
    repeat (12) @(negedge clk_i);
  endtask : wr
  task automatic ctl_chk(input logic [15:0] w);
    logic on;
    on = w[0] & power_down_control_n_i;
    got = ctrl_o;
    cmp("ctrl", {2'h0, on & w[6] & idle_n_i, on & w[5], on & w[4], on & (idle_n_i | w[1]), w[3],
      w[7], w[8],
      w[9], w[10], w[12:11], (w[15] ? w[14:13] : 2'b00), w[15]}, {2'h0, got});
  endtask : ctl_chk
  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    wr(16'hffff, 4'hf);
    cmp("main", 16'h2616, main_divider_ratio_o);
    cmp("refdiv", 16'h0050, {7'h0, reference_divide_value_o});
    cmp("pump", 16'h0000, {13'h0, pump_test_select_o});
    ctl_chk(16'h197d);
    wr(16'h1234, 4'h2);
    cmp("main", 16'h1234, main_divider_ratio_o);
    wr(16'hedcb, 4'h2, 1'b0);
    wr(16'h5abc, 4'h0);
    cmp("refdiv", 16'h00bc, {7'h0, reference_divide_value_o});
    cmp("pump", 16'h0003, {13'h0, pump_test_select_o});
    wr(16'hffff, 4'h6);
    cmp("main", 16'h1234, main_divider_ratio_o);
    cmp("refdiv", 16'h00bc, {7'h0, reference_divide_value_o});
    foreach (cw[i]) begin
      wr(cw[i], 4'h4);
      ctl_chk(cw[i]);
    end
    foreach (pv[i]) begin
      {idle_n_i, power_down_control_n_i} = pv[i];
      repeat (8) @(negedge clk_i);
      ctl_chk(16'h9efd);
    end
    for (int s = 0; s < 4; s++) begin
      wr({5'h08, s[1:0], 9'h050}, 4'h0);
      for (int v = 0; v < 2; v++) begin
        src = v ? 3'b010 : 3'b101;
        repeat (2) @(negedge clk_i);
        cmp("lock", {15'h0, (s == 3) ? 1'b0 : src[s]}, {15'h0, lock_indicator_o});
      end
    end
    stop_test();
  end
endmodule : test_tsc_serial_regs

// >>> tb/tsc_host_model.sv
`timescale 1ns/10ps
module tsc_host_model (
  output logic link_clk_o,
  output logic select_n_o,
  output logic data_o
);
  initial begin
    link_clk_o = 1'b0;
    select_n_o = 1'b1;
    data_o     = 1'b0;
  end
  // Clock runs only inside a frame; sel low keeps the device deselected
  task automatic send(input logic [15:0] d, input logic [3:0] a, input logic sel);
    logic [19:0] f;
    f = {d, a};
    #37 select_n_o = ~sel;
    for (int i = 19; i >= 0; i--) begin
      data_o = f[i];
      #80 link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
    end
    #80 select_n_o = 1'b1;
    data_o = ~data_o;
    #200;
  endtask : send
endmodule : tsc_host_model

// >>> tb/tsc_regs_sva.sv
`timescale 1ns/10ps
module tsc_regs_chk
  import tsc_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         select_n_i,
  input wire logic         power_down_control_n_i,
  input wire logic         idle_n_i,
  input wire logic [15:0]  main_divider_ratio_o,
  input wire logic [8:0]   reference_divide_value_o,
  input wire logic [2:0]   pump_test_select_o,
  input wire tsc_ctrl_type ctrl_o
);
  logic [3:0] cnt_q;
  logic       sel_q;
  logic [1:0] pin_q;
  always_ff @(posedge clk_i) begin
    sel_q <= select_n_i;
    pin_q <= {idle_n_i, power_down_control_n_i};
  end
  // Cycles since frame end, pin change or reset
  always_ff @(posedge clk_i) begin
    if (rst_i || (select_n_i && !sel_q) || pin_q != {idle_n_i, power_down_control_n_i}) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence power_down_control_held;
    !power_down_control_n_i [*8];
  endsequence
  sequence idle_held;
    !idle_n_i [*8];
  endsequence
  a_main_upd_win: assert property ($changed(main_divider_ratio_o) |-> cnt_q < 4'ha)
    else $error("main divider moved late");
  a_ref_upd_win: assert property ($changed(reference_divide_value_o) |-> cnt_q < 4'ha)
    else $error("reference value moved late");
  a_pump_upd_win: assert property ($changed(pump_test_select_o) |-> cnt_q < 4'ha)
    else $error("pump test moved late");
  a_ctrl_upd_win: assert property ($changed(ctrl_o) |-> cnt_q < 4'hc)
    else $error("controls moved late");
  a_frame_hold: assert property (!select_n_i [*8] |-> $stable(main_divider_ratio_o))
    else $error("main divider moved mid frame");
  a_power_down_control_pin_off: assert property (power_down_control_held |->
    !ctrl_o.pll_on && !ctrl_o.oscillator_on && !ctrl_o.tx_chain_on)
    else $error("shutdown pin ignored");
  a_idle_tx_off: assert property (idle_held |-> !ctrl_o.tx_chain_on)
    else $error("idle pin ignored");
  a_trim_gate: assert property (!ctrl_o.offset_trim_mode |->
    ctrl_o.offset_correction_current == 2'h0)
    else $error("offset current outside trim");
endmodule : tsc_regs_chk

bind tsc_serial_regs tsc_regs_chk chk_u (.clk_i, .rst_i, .select_n_i, .power_down_control_n_i,
  .idle_n_i, .main_divider_ratio_o, .reference_divide_value_o, .pump_test_select_o, .ctrl_o);

// >>> verilog/tsc_pkg.sv
package tsc_pkg;

  localparam int FRAME_BITS = 20;
  localparam int ADDR_BITS  = 4;
  localparam int DATA_BITS  = 16;

  localparam logic [3:0] ADDR_REFERENCE_DIVIDER = 4'h0;
  localparam logic [3:0] ADDR_MAIN_DIVIDER      = 4'h2;
  localparam logic [3:0] ADDR_OPERATION_CONTROL = 4'h4;

  localparam logic [15:0] RST_REFERENCE_DIVIDER = 16'h4050;
  localparam logic [15:0] RST_MAIN_DIVIDER      = 16'h2616;
  localparam logic [15:0] RST_OPERATION_CONTROL = 16'h197d;

  // Operation control bit positions
  localparam int OC_POWER_DOWN_CONTROL    = 0;
  localparam int OC_FILTER_KEEP_ON        = 1;
  localparam int OC_BASEBAND_FILTER_EN    = 3;
  localparam int OC_PLL_ENABLE            = 4;
  localparam int OC_OSCILLATOR_ENABLE     = 5;
  localparam int OC_TX_CHAIN_ENABLE       = 6;
  localparam int OC_REF_DOUBLER_ENABLE    = 7;
  localparam int OC_MAX_POWER_SELECT      = 8;
  localparam int OC_PREDRIVER_BIAS_SELECT = 9;
  localparam int OC_OUTPUT_BIAS_SELECT    = 10;
  localparam int OC_CHARGE_PUMP_LSB       = 11;
  localparam int OC_OFFSET_CURRENT_LSB    = 13;
  localparam int OC_OFFSET_TRIM_MODE      = 15;

  // Reference divider field positions
  localparam int RD_DIVIDE_WIDTH     = 9;
  localparam int RD_LOCK_SELECT_LSB  = 9;
  localparam int RD_PUMP_TEST_LSB    = 11;

  typedef enum logic [1:0] {
    LOCK_SRC_DETECT,
    LOCK_SRC_MAIN_DIV,
    LOCK_SRC_REF_DIV,
    LOCK_SRC_LOW
  } tsc_lock_sel_type;

  typedef struct packed {
    logic tx_chain_on;
    logic oscillator_on;
    logic pll_on;
    logic baseband_filter_on;
    logic filter_route;
    logic ref_doubler_on;
    logic max_power_high;
    logic predriver_bias_nominal;
    logic output_bias_high;
    logic [1:0] charge_pump_current;
    logic [1:0] offset_correction_current;
    logic offset_trim_mode;
  } tsc_ctrl_type;

endpackage : tsc_pkg

// >>> verilog/tsc_serial_regs.sv
`timescale 1ns/10ps
// Function
// - Three 16-bit registers, each loaded from one 20-bit serial frame.
// - Frame low four bits are the register address.
// - Frame high sixteen bits are the register data.
// - Data shifts in on serial clock rising edge while select low.
// - Select rising copies data field into the addressed register once synchronised into clk_i.
// - Address 0 reference, 2 main, 4 control; others change nothing.
// - Power-up values: main 9750, reference 4050 hex, control 197d hex.
// - Oscillator frequency is reference times main over reference divider.
// - Control bit 0 low or shutdown pin low powers down PLL, oscillator, transmit chain and filters.
// - Control bit 1 keeps filters on during idle; zero turns them off.
// - Control bit 3 low bypasses filters, high routes through them.
// - Bits 4, 5, 6 low disable PLL, oscillator and transmit chain.
// - Control bit 7 enables reference doubler ahead of reference divider.
// - Control bit 8 selects higher or lower maximum output power.
// - Bit 9 predriver bias reduced/nominal; bit 10 output bias nominal/increased.
// - Bits 12:11 select charge-pump current in four steps.
// - Bits 14:13 select offset-correction current, used only in trim mode.
// - Control bit 15 enables offset trimming mode.
// - Lock output follows PLL lock detect when reference bits 10:9 are 0; 1 gives main divider, 2 reference divider, 3 low.
// - Idle keeps oscillator, PLL and serial port on; transmit chain off, filters off unless bit 1 set.
// - Idle pin low enters idle with oscillator and PLL active.
// - Reference divider bits 8:0 hold the reference divide value.
// - Reference bits 10:9 pick lock output source.
module tsc_serial_regs
  import tsc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 link_clk_i,
  input  wire logic                 select_n_i,
  input  wire logic                 serial_data_in_i,
  input  wire logic                 power_down_control_n_i,
  input  wire logic                 idle_n_i,
  input  wire logic                 pll_lock_detect_i,
  input  wire logic                 main_div_out_i,
  input  wire logic                 ref_div_out_i,
  output logic [15:0]               main_divider_ratio_o,
  output logic [RD_DIVIDE_WIDTH-1:0] reference_divide_value_o,
  output logic [2:0]                pump_test_select_o,
  output tsc_ctrl_type              ctrl_o,
  output logic                      lock_indicator_o
);

  // Indices of the inputs that come from outside the clk_i domain
  localparam int PIN_COUNT  = 3;
  localparam int PIN_SELECT = 0;
  localparam int PIN_POWER  = 1;
  localparam int PIN_IDLE   = 2;
  localparam int SYNC_DEPTH = 3;

  // Link domain: the shift register is the only logic on the link clock
  logic [FRAME_BITS-1:0] shift_q;

  always_ff @(posedge link_clk_i) begin
    if (!select_n_i) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], serial_data_in_i};
    end
  end

  // True when the addressed register is the one given
  function automatic logic addr_hit(input logic [ADDR_BITS-1:0] addr,
                                    input logic [ADDR_BITS-1:0] target);
    return addr == target;
  endfunction : addr_hit

  // Select and the two control pins each pass three flops into clk_i
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_acc;

  assign pin_raw[PIN_SELECT] = select_n_i;
  assign pin_raw[PIN_POWER]  = power_down_control_n_i;
  assign pin_raw[PIN_IDLE]   = idle_n_i;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      logic [SYNC_DEPTH-1:0] stage_q;
      logic                  acc_q;

      always_ff @(posedge clk_i) begin
        stage_q <= {stage_q[SYNC_DEPTH-2:0], pin_raw[g]};
      end

      // A new level counts once the last two stages agree
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          acc_q <= 1'b1;
        end else if (stage_q[SYNC_DEPTH-2] == stage_q[SYNC_DEPTH-1]) begin
          acc_q <= stage_q[SYNC_DEPTH-1];
        end
      end

      assign pin_acc[g] = acc_q;
    end
  endgenerate

  logic sel_n_acc;
  logic pd_n_acc;
  logic idle_n_acc;

  assign sel_n_acc  = pin_acc[PIN_SELECT];
  assign pd_n_acc   = pin_acc[PIN_POWER];
  assign idle_n_acc = pin_acc[PIN_IDLE];

  // Deselect edge seen in clk_i; the shift register is frozen by then
  logic sel_prev_q;
  logic frame_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_prev_q <= 1'b1;
    end else begin
      sel_prev_q <= sel_n_acc;
    end
  end

  assign frame_ev = sel_n_acc && !sel_prev_q;

  logic [ADDR_BITS-1:0] frame_addr;
  logic [DATA_BITS-1:0] frame_data;

  assign frame_addr = shift_q[ADDR_BITS-1:0];
  assign frame_data = shift_q[FRAME_BITS-1:ADDR_BITS];

  logic [DATA_BITS-1:0] ref_q;
  logic [DATA_BITS-1:0] main_q;
  logic [DATA_BITS-1:0] ctl_q;

  // Unknown addresses match none of the three loads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= RST_REFERENCE_DIVIDER;
    end else if (frame_ev && addr_hit(frame_addr, ADDR_REFERENCE_DIVIDER)) begin
      ref_q <= frame_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_q <= RST_MAIN_DIVIDER;
    end else if (frame_ev && addr_hit(frame_addr, ADDR_MAIN_DIVIDER)) begin
      main_q <= frame_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= RST_OPERATION_CONTROL;
    end else if (frame_ev && addr_hit(frame_addr, ADDR_OPERATION_CONTROL)) begin
      ctl_q <= frame_data;
    end
  end

  // Power state from pins and control bit 0
  logic run;
  logic awake;

  assign run   = pd_n_acc && ctl_q[OC_POWER_DOWN_CONTROL];
  assign awake = run && idle_n_acc;

  logic       pll_on_q;
  logic       osc_on_q;
  logic       tx_on_q;
  logic       filt_on_q;
  logic       route_q;
  logic       doubler_q;
  logic       max_pwr_q;
  logic       pre_bias_q;
  logic       out_bias_q;
  logic [1:0] pump_cur_q;
  logic [1:0] offset_cur_q;
  logic       trim_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_on_q <= 1'b0;
    end else begin
      pll_on_q <= run && ctl_q[OC_PLL_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_on_q <= 1'b0;
    end else begin
      osc_on_q <= run && ctl_q[OC_OSCILLATOR_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_on_q <= 1'b0;
    end else begin
      tx_on_q <= awake && ctl_q[OC_TX_CHAIN_ENABLE];
    end
  end

  // Filters stay up in idle only when the keep-on bit is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_on_q <= 1'b0;
    end else begin
      filt_on_q <= run && (idle_n_acc || ctl_q[OC_FILTER_KEEP_ON]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_q <= 1'b0;
    end else begin
      route_q <= ctl_q[OC_BASEBAND_FILTER_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      doubler_q <= 1'b0;
    end else begin
      doubler_q <= ctl_q[OC_REF_DOUBLER_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_pwr_q <= 1'b0;
    end else begin
      max_pwr_q <= ctl_q[OC_MAX_POWER_SELECT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_bias_q <= 1'b0;
    end else begin
      pre_bias_q <= ctl_q[OC_PREDRIVER_BIAS_SELECT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_bias_q <= 1'b0;
    end else begin
      out_bias_q <= ctl_q[OC_OUTPUT_BIAS_SELECT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pump_cur_q <= 2'h0;
    end else begin
      pump_cur_q <= ctl_q[OC_CHARGE_PUMP_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_q <= 1'b0;
    end else begin
      trim_q <= ctl_q[OC_OFFSET_TRIM_MODE];
    end
  end

  // Offset current is only passed on while trimming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_cur_q <= 2'h0;
    end else if (ctl_q[OC_OFFSET_TRIM_MODE]) begin
      offset_cur_q <= ctl_q[OC_OFFSET_CURRENT_LSB +: 2];
    end else begin
      offset_cur_q <= 2'h0;
    end
  end

  assign ctrl_o = '{
    tx_chain_on:               tx_on_q,
    oscillator_on:             osc_on_q,
    pll_on:                    pll_on_q,
    baseband_filter_on:        filt_on_q,
    filter_route:              route_q,
    ref_doubler_on:            doubler_q,
    max_power_high:            max_pwr_q,
    predriver_bias_nominal:    pre_bias_q,
    output_bias_high:          out_bias_q,
    charge_pump_current:       pump_cur_q,
    offset_correction_current: offset_cur_q,
    offset_trim_mode:          trim_q
  };

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_divider_ratio_o <= RST_MAIN_DIVIDER;
    end else begin
      main_divider_ratio_o <= main_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reference_divide_value_o <= RST_REFERENCE_DIVIDER[RD_DIVIDE_WIDTH-1:0];
    end else begin
      reference_divide_value_o <= ref_q[RD_DIVIDE_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pump_test_select_o <= RST_REFERENCE_DIVIDER[RD_PUMP_TEST_LSB +: 3];
    end else begin
      pump_test_select_o <= ref_q[RD_PUMP_TEST_LSB +: 3];
    end
  end

  tsc_lock_sel_type lock_sel;
  logic             lock_d;
  assign lock_sel = tsc_lock_sel_type'(ref_q[RD_LOCK_SELECT_LSB +: 2]);

  always_comb begin
    unique case (lock_sel)
      LOCK_SRC_DETECT:   lock_d = pll_lock_detect_i;
      LOCK_SRC_MAIN_DIV: lock_d = main_div_out_i;
      LOCK_SRC_REF_DIV:  lock_d = ref_div_out_i;
      LOCK_SRC_LOW:      lock_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_indicator_o <= 1'b0;
    end else begin
      lock_indicator_o <= lock_d;
    end
  end

endmodule : tsc_serial_regs
